// *** design/sad_ctrl.sv ***
// Converter trigger, channel select and sequencing with Wishbone slave.
// Assumes trigger pin and comparator are asynchronous; timer and PROGRAMMABLE_LOGIC_ARRAY
// pulses come from logic on clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "sad_params.svh"

// Operation
// - Trigger field picks pin, timer1, timer0, one-shot, continuous, PROGRAMMABLE_LOGIC_ARRAY.
// - Positive codes 0-11 pick inputs, 12-15 the shared DAC pins.
// - Positive codes 16-19 pick temp, ground, reference, half supply.
// - Negative codes 0-15 match positive; 16 picks reference.
// - Select registers are 8 bits, upper three reserved, read zero.
// - Inputs connect in acquisition, disconnect for whole conversion.
// - SAR steps charge until balanced, then flags done with code.
// - Single-ended ties negative switch to ground whenever enabled, powered and all codes legal.
// - Pseudo-differential: negative pin in acquisition, reference after.
// - Mode field bits 4-3: single, differential, pseudo, reserved.
// - Status bit 0 set at conversion end, cleared by result read.
// - Busy pin high during conversion when enabled.
// - Result in bits 27-16, sign above, two's complement if diff.
module sad_ctrl (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  output logic                   err_o,
  // Trigger sources
  input  wire logic              ext_trig_pin_i,
  input  wire logic              tmr0_ovf_i,
  input  wire logic              tmr1_ovf_i,
  input  wire logic              pla_trig_i,
  // Analog front end
  input  wire logic              cmp_i,
  output sad_pkg::sad_front_s    front_o,
  output logic [11:0]            dac_o,
  output logic                   adc_power_o,
  // Pins and interrupt
  output logic                   busy_pin_o,
  output logic                   irq_o
);

  // ****************************************************************
  // Registers and synchronisers
  // ****************************************************************
  logic [7:0]  ctrl_r;
  logic [4:0]  psel_r;
  logic [4:0]  nsel_r;
  logic        stat_r;
  logic        mask_r;
  logic [31:0] result_r;
  logic [1:0]  pin_sync_r;
  logic [1:0]  cmp_sync_r;
  logic        pin_prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync_r <= 2'h0;
      cmp_sync_r <= 2'h0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], ext_trig_pin_i};
      cmp_sync_r <= {cmp_sync_r[0], cmp_i};
      pin_prev_r <= pin_sync_r[1];
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  sad_pkg::sad_trig_e trig;
  sad_pkg::sad_mode_e mode;
  logic conv_en;
  logic trig_ok;
  logic mode_ok;
  logic psel_ok;
  logic nsel_ok;
  logic cfg_ok;

  assign conv_en = ctrl_r[`SAD_CTRL_EN_BIT] & ctrl_r[`SAD_CTRL_PWR_BIT];
  assign trig = sad_pkg::sad_trig_e'(ctrl_r[`SAD_CTRL_TRIG_HI:`SAD_CTRL_TRIG_LO]);
  assign mode = sad_pkg::sad_mode_e'(ctrl_r[`SAD_CTRL_MODE_HI:`SAD_CTRL_MODE_LO]);
  assign trig_ok = ctrl_r[`SAD_CTRL_TRIG_HI:`SAD_CTRL_TRIG_LO] <= 3'h5;
  assign mode_ok = mode != sad_pkg::MODE_RSVD;
  assign psel_ok = psel_r <= `SAD_CH_HALF_AVDD;
  // Negative field only matters outside single-ended mode
  assign nsel_ok = (mode == sad_pkg::MODE_SINGLE) || (nsel_r <= `SAD_NCH_REF);
  assign cfg_ok = conv_en & trig_ok & mode_ok & psel_ok & nsel_ok;

  // ****************************************************************
  // Wishbone access
  // ****************************************************************
  logic acc;
  logic wr;
  logic rd_result;
  logic hit;

  assign acc = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr  = acc & we_i & sel_i[0];

  always_comb begin
    hit = 1'b1;
    if (adr_i == `SAD_OFS_CTRL) begin
      hit = 1'b1;
    end else if (adr_i == `SAD_OFS_PSEL) begin
      hit = 1'b1;
    end else if (adr_i == `SAD_OFS_NSEL) begin
      hit = 1'b1;
    end else if (adr_i == `SAD_OFS_STATUS) begin
      hit = 1'b1;
    end else if (adr_i == `SAD_OFS_RESULT) begin
      hit = 1'b1;
    end else if (adr_i == `SAD_OFS_IMASK) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign rd_result = acc & ~we_i & (adr_i == `SAD_OFS_RESULT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc & hit;
      err_o <= acc & ~hit;
      if (acc & ~we_i) begin
        if (adr_i == `SAD_OFS_CTRL) begin
          dat_o <= {24'h00_0000, ctrl_r};
        end else if (adr_i == `SAD_OFS_PSEL) begin
          dat_o <= {27'h000_0000, psel_r};
        end else if (adr_i == `SAD_OFS_NSEL) begin
          dat_o <= {27'h000_0000, nsel_r};
        end else if (adr_i == `SAD_OFS_STATUS) begin
          dat_o <= {31'h0000_0000, stat_r};
        end else if (adr_i == `SAD_OFS_RESULT) begin
          dat_o <= result_r;
        end else if (adr_i == `SAD_OFS_IMASK) begin
          dat_o <= {31'h0000_0000, mask_r};
        end else begin
          dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SAD_CTRL_RST;
      psel_r <= 5'h00;
      nsel_r <= 5'h00;
      mask_r <= 1'b0;
    end else if (wr) begin
      if (adr_i == `SAD_OFS_CTRL) begin
        ctrl_r <= dat_i[7:0];
      end else if (adr_i == `SAD_OFS_PSEL) begin
        psel_r <= dat_i[4:0];
      end else if (adr_i == `SAD_OFS_NSEL) begin
        nsel_r <= dat_i[4:0];
      end else if (adr_i == `SAD_OFS_IMASK) begin
        mask_r <= dat_i[0];
      end
    end
  end

  // ****************************************************************
  // Trigger selection
  // ****************************************************************
  logic one_shot_r;
  logic ctrl_wr;
  logic trig_pulse;

  assign ctrl_wr = wr & (adr_i == `SAD_OFS_CTRL);

  // One-shot armed by each control write selecting it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      one_shot_r <= 1'b0;
    end else if (ctrl_wr) begin
      one_shot_r <= dat_i[`SAD_CTRL_TRIG_HI:`SAD_CTRL_TRIG_LO] == 3'h3;
    end else if (trig_pulse) begin
      one_shot_r <= 1'b0;
    end
  end

  always_comb begin
    case (trig)
      sad_pkg::TRG_PIN:     trig_pulse = pin_sync_r[1] & ~pin_prev_r;
      sad_pkg::TRG_TMR1:    trig_pulse = tmr1_ovf_i;
      sad_pkg::TRG_TMR0:    trig_pulse = tmr0_ovf_i;
      sad_pkg::TRG_SW_ONE:  trig_pulse = one_shot_r;
      sad_pkg::TRG_SW_CONT: trig_pulse = 1'b1;
      sad_pkg::TRG_PLA:     trig_pulse = pla_trig_i;
      default:              trig_pulse = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} sad_state_e;
  sad_state_e state_r;
  logic [7:0] acq_cnt_r;
  logic       sar_done;
  logic       sar_active;
  logic [11:0] sar_code;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      acq_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Continuous mode re-enters here after each result
          if (cfg_ok && trig_pulse) begin
            state_r   <= ST_ACQ;
            acq_cnt_r <= 8'(`SAD_ACQ_CYC - 1);
          end
        end
        ST_ACQ: begin
          if (!cfg_ok) begin
            state_r <= ST_IDLE;
          end else if (acq_cnt_r == 8'h00) begin
            state_r <= ST_CONV;
          end else begin
            acq_cnt_r <= acq_cnt_r - 8'h01;
          end
        end
        ST_CONV: begin
          if (sar_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  sad_sar u_sar (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (state_r == ST_ACQ && acq_cnt_r == 8'h00 && cfg_ok),
    .done_o   (sar_done),
    .active_o (sar_active),
    .cmp_i    (cmp_sync_r[1]),
    .dac_o    (dac_o),
    .code_o   (sar_code)
  );

  // Result, status and interrupt
  logic [11:0] signed_code;
  assign signed_code = (mode == sad_pkg::MODE_DIFF) ? (sar_code ^ 12'h8_00) : sar_code;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= 32'h0000_0000;
      stat_r   <= 1'b0;
    end else begin
      if (sar_done) begin
        result_r <= {{4{(mode == sad_pkg::MODE_DIFF) & signed_code[11]}},
                     signed_code, 16'h0000};
      end
      // Completion wins over a same-cycle result read
      if (sar_done) begin
        stat_r <= 1'b1;
      end else if (rd_result) begin
        stat_r <= 1'b0;
      end
    end
  end

  assign irq_o = stat_r & mask_r;

  // ****************************************************************
  // Front-end switch control
  // ****************************************************************
  always_comb begin
    front_o = '0;
    front_o.pos_chan = psel_r;
    front_o.neg_chan = nsel_r;
    // Reserved codes route nothing
    if (cfg_ok) begin
      front_o.pos_connect = state_r == ST_ACQ;
      front_o.balance     = state_r != ST_CONV;
      case (mode)
        sad_pkg::MODE_SINGLE: front_o.neg_to_gnd = 1'b1;
        sad_pkg::MODE_PSEUDO: begin
          front_o.neg_connect = state_r == ST_ACQ;
          front_o.neg_to_ref  = state_r == ST_CONV;
        end
        sad_pkg::MODE_DIFF: front_o.neg_connect = state_r == ST_ACQ;
        default: front_o.neg_to_gnd = 1'b0;
      endcase
    end
  end

  assign adc_power_o = ctrl_r[`SAD_CTRL_PWR_BIT];
  assign busy_pin_o = ctrl_r[`SAD_CTRL_BUSY_BIT] & sar_active;

endmodule : sad_ctrl
`default_nettype wire

// *** design/sad_params.svh ***
// Register offsets, field positions, reset values and timing counts
// for the converter trigger and channel select block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef SAD_PARAMS_SVH
`define SAD_PARAMS_SVH

// Register byte addresses on the Wishbone slave
`define SAD_OFS_CTRL      8'h00
`define SAD_OFS_PSEL      8'h04
`define SAD_OFS_NSEL      8'h08
`define SAD_OFS_STATUS    8'h0C
`define SAD_OFS_RESULT    8'h10
`define SAD_OFS_IMASK     8'h14

// Control register fields
`define SAD_CTRL_EN_BIT   7
`define SAD_CTRL_BUSY_BIT 6
`define SAD_CTRL_PWR_BIT  5
`define SAD_CTRL_MODE_HI  4
`define SAD_CTRL_MODE_LO  3
`define SAD_CTRL_TRIG_HI  2
`define SAD_CTRL_TRIG_LO  0

// Result placement
`define SAD_RES_LO        16
`define SAD_RES_HI        27

// Channel codes
`define SAD_CH_LAST_PIN   5'h0_F
`define SAD_CH_TEMP       5'h1_0
`define SAD_CH_AGND       5'h1_1
`define SAD_CH_REF        5'h1_2
`define SAD_CH_HALF_AVDD  5'h1_3
`define SAD_NCH_REF       5'h1_0

// Reset values
`define SAD_CTRL_RST      8'h0_0
`define SAD_SEL_RST       8'h0_0

// Timing: acquisition time in ns, cycles at 8 ns clock
`define SAD_ACQ_NS        200
`define SAD_CLK_NS        8
`define SAD_ACQ_CYC       ((`SAD_ACQ_NS + `SAD_CLK_NS - 1) / `SAD_CLK_NS)
`define SAD_BITS          12
// Cycles a trial code waits for the comparator synchroniser to catch up
`define SAD_CMP_SETTLE    2'h2

`endif

// *** design/sad_pkg.sv ***
// Types shared by the converter control block.
// Assumes sad_params.svh is reachable by bare name.
package sad_pkg;

  typedef enum logic [2:0] {
    TRG_PIN, TRG_TMR1, TRG_TMR0, TRG_SW_ONE, TRG_SW_CONT, TRG_PLA
  } sad_trig_e;

  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_DIFF, MODE_PSEUDO, MODE_RSVD
  } sad_mode_e;

  // Switch commands toward the analog front end
  typedef struct packed {
    logic       pos_connect;   // Positive array on selected input
    logic [4:0] pos_chan;
    logic       neg_connect;   // Negative switch on negative pin
    logic       neg_to_ref;    // Negative switch on reference
    logic       neg_to_gnd;    // Negative switch on ground
    logic [4:0] neg_chan;
    logic       balance;       // Comparator balance switch closed
  } sad_front_s;

endpackage : sad_pkg

// *** design/sad_sar.sv ***
// Successive approximation step engine.
// Assumes comparator output is already synchronised to clk_i, two
// flip-flops deep, so each trial waits that long before it is judged.
`timescale 1ns/1ns
`default_nettype none
`include "sad_params.svh"

module sad_sar (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        start_i,
  output logic             done_o,
  output logic             active_o,
  // Analog side
  input  wire logic        cmp_i,
  output logic [11:0]      dac_o,
  output logic [11:0]      code_o
);

  logic [11:0] trial_r;
  logic [11:0] bit_r;
  logic [1:0]  wait_r;

  // Bitwise charge steps until balanced
  // Judging a trial before the synchroniser settles would use the
  // answer to the previous trial, so three cycles per bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trial_r  <= 12'h0_00;
      bit_r    <= 12'h0_00;
      wait_r   <= 2'h0;
      active_o <= 1'b0;
      done_o   <= 1'b0;
      code_o   <= 12'h0_00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !active_o) begin
        bit_r    <= 12'h8_00;
        trial_r  <= 12'h8_00;
        wait_r   <= `SAD_CMP_SETTLE;
        active_o <= 1'b1;
      end else if (active_o && (wait_r != 2'h0)) begin
        wait_r <= wait_r - 2'h1;
      end else if (active_o) begin
        wait_r <= `SAD_CMP_SETTLE;
        // Comparator high means trial exceeds input: drop the bit
        if (bit_r == 12'h0_01) begin
          code_o   <= cmp_i ? (trial_r & ~bit_r) : trial_r;
          active_o <= 1'b0;
          done_o   <= 1'b1;
        end else begin
          trial_r <= (cmp_i ? (trial_r & ~bit_r) : trial_r) | (bit_r >> 1);
        end
        bit_r <= bit_r >> 1;
      end
    end
  end

  assign dac_o = trial_r;

endmodule : sad_sar
`default_nettype wire

// *** tb/sad_ctrl_checker.sv ***
// Port checker for the converter control block.
// Assumes a bind onto sad_ctrl; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "sad_params.svh"
module sad_ctrl_checker (
  // Clock, reset and bus
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic                ack_o,
  input  wire logic                err_o,
  // Converter side
  input  wire sad_pkg::sad_front_s front_o,
  input  wire logic                busy_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       req;
  logic [5:0] bcnt_r;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  // Saturates so a stuck busy cannot wrap into the legal window
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_pin_o) bcnt_r <= 6'h00;
    else if (bcnt_r != 6'h3F) bcnt_r <= bcnt_r + 6'h01;
  end
  sequence s_take; req; endsequence
  sequence s_acq; front_o.pos_connect [*8]; endsequence
  ack_answer_a: assert property (s_take |=> ack_o ^ err_o)
    else $error("bus request not answered in one cycle");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  err_unmapped_a: assert property (req && !(adr_i inside {`SAD_OFS_CTRL,
    `SAD_OFS_PSEL, `SAD_OFS_NSEL, `SAD_OFS_STATUS, `SAD_OFS_RESULT,
    `SAD_OFS_IMASK}) |=> err_o && !ack_o)
    else $error("unmapped address not refused");
  conv_isolate_a: assert property (
    busy_pin_o |-> !front_o.pos_connect && !front_o.neg_connect
    && !front_o.balance) else $error("input connected during conversion");
  neg_onehot_a: assert property (
    $onehot0({front_o.neg_connect, front_o.neg_to_ref, front_o.neg_to_gnd}))
    else $error("negative switch in two positions");
  pseudo_ref_a: assert property (
    $rose(front_o.neg_to_ref) |-> $past(front_o.neg_connect)
    && !front_o.pos_connect) else $error("reference not after negative pin");
  acq_hold_a: assert property (
    $rose(front_o.pos_connect) |-> s_acq)
    else $error("acquisition cut short");
  // Twelve bits at three cycles each
  busy_len_a: assert property (
    $fell(busy_pin_o) |-> bcnt_r == 6'h24)
    else $error("busy length wrong");
endmodule : sad_ctrl_checker
bind sad_ctrl sad_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i), .ack_o(ack_o), .err_o(err_o),
  .front_o(front_o), .busy_pin_o(busy_pin_o));
`default_nettype wire

// *** tb/sad_front_model.sv ***
// Analog front end stand-in: comparator against a held input level.
// Assumes the bench sets vin_i before each conversion starts.
`timescale 1ns/1ns
`default_nettype none
module sad_front_model (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Converter side
  input  wire sad_pkg::sad_front_s front_i,
  input  wire logic [11:0]         dac_i,
  input  wire logic [11:0]         vin_i,
  output logic                     cmp_o
);
  logic tog_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) tog_r <= 1'b0;
    else tog_r <= !tog_r;
  end
  // Balanced comparator gives no usable answer, so it wanders
  assign cmp_o = front_i.balance ? tog_r : (dac_i > vin_i);
endmodule : sad_front_model
`default_nettype wire

// *** tb/test_sad_ctrl.sv ***
// Self-checking bench for the converter control block.
// Assumes sad_ctrl with the front end model on its analog side.
`timescale 1ns/1ns
`default_nettype none
`include "sad_params.svh"
module test_sad_ctrl;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic        we_i = 1'b0, ext_trig_pin_i = 1'b0, pla_trig_i = 1'b0;
  logic        tmr0_ovf_i = 1'b0, tmr1_ovf_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [11:0] dac_o, vin = 12'h000;
  logic        ack_o, err_o, cmp_i, busy_pin_o, irq_o, adc_power_o, e, s;
  sad_pkg::sad_front_s front_o;
  int          n_errors = 0, cmp_count = 0, ticks = 0;
  always #4 clk_i = !clk_i;
  sad_ctrl DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .ext_trig_pin_i, .tmr0_ovf_i,
    .tmr1_ovf_i, .pla_trig_i, .cmp_i, .front_o, .dac_o, .adc_power_o,
    .busy_pin_o, .irq_o);
  sad_front_model u_fe (.clk_i, .rst_i, .front_i(front_o), .dac_i(dac_o),
    .vin_i(vin), .cmp_o(cmp_i));
  // ********************
  // Shared tasks
  // ********************
  task automatic close_out;
    $display("Compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] x, seen);
    cmp_count++;
    if (seen !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus
  task automatic fire(input logic [3:0] f);
    @(posedge clk_i);
    {pla_trig_i, tmr0_ovf_i, tmr1_ovf_i, ext_trig_pin_i} <= f;
    repeat (3) @(posedge clk_i);
    {pla_trig_i, tmr0_ovf_i, tmr1_ovf_i, ext_trig_pin_i} <= 4'h0;
  endtask : fire
  task automatic wirq;
    for (int i = 0; i < 100 && irq_o !== 1'b1; i++) @(posedge clk_i);
  endtask : wirq
  // ********************
  // Scenarios
  // ********************
  task automatic run(input logic [7:0] c, input logic [4:0] p, n,
                     input logic [11:0] v, input logic [3:0] f);
    logic [31:0] x;
    x = c[4:3] == 2'b01 ? {{4{!v[11]}}, v ^ 12'h800, 16'h0000}
                        : {4'h0, v, 16'h0000};
    vin <= v;
    bus(1'b1, `SAD_OFS_PSEL, {27'h0, p});
    bus(1'b1, `SAD_OFS_NSEL, {27'h0, n});
    bus(1'b1, `SAD_OFS_CTRL, {24'h0, c});
    fire(f);
    for (int i = 0; i < 40 && front_o.pos_connect !== 1'b1; i++)
      @(posedge clk_i);
    chk("pos_chan", {27'h0, p}, {27'h0, front_o.pos_chan});
    chk("neg_sw", c[4:3] == 2'b00 ? 32'h1 : 32'h4, {29'h0,
      front_o.neg_connect, front_o.neg_to_ref, front_o.neg_to_gnd});
    if (c[4:3] != 2'b00)
      chk("neg_chan", {27'h0, n}, {27'h0, front_o.neg_chan});
    wirq;
    chk("irq", 32'h1, {31'h0, irq_o});
    bus(1'b0, `SAD_OFS_RESULT, 32'h0);
    chk("result", x, rd);
    bus(1'b0, `SAD_OFS_STATUS, 32'h0);
    chk("status", 32'h0, rd);
  endtask : run
  task automatic rsv(input logic [7:0] c, input logic [4:0] p, n,
                     input logic [3:0] f);
    bus(1'b1, `SAD_OFS_PSEL, {27'h0, p});
    bus(1'b1, `SAD_OFS_NSEL, {27'h0, n});
    bus(1'b1, `SAD_OFS_CTRL, {24'h0, c});
    fire(f);
    s = 1'b0;
    repeat (60) begin
      @(posedge clk_i);
      s = s | front_o.pos_connect;
    end
    chk("rsv_irq", 32'h0, {31'h0, irq_o});
    chk("rsv_route", 32'h0, {31'h0, s});
  endtask : rsv
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 8000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      if (i != 4) chk("reset", 32'h0, rd);
    end
    bus(1'b1, `SAD_OFS_PSEL, 32'hFF);
    bus(1'b0, `SAD_OFS_PSEL, 32'h0);
    chk("psel_top", 32'h1F, rd);
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    bus(1'b1, `SAD_OFS_IMASK, 32'h1);
    run(8'hE3, 5'h03, 5'h00, 12'h5A3, 4'h0);
    run(8'hF3, 5'h0B, 5'h05, 12'hFFF, 4'h0);
    run(8'hEB, 5'h0C, 5'h0F, 12'h123, 4'h0);
    run(8'hE0, 5'h10, 5'h00, 12'h800, 4'h1);
    run(8'hE1, 5'h11, 5'h00, 12'h001, 4'h2);
    run(8'hE2, 5'h12, 5'h00, 12'h7FF, 4'h4);
    run(8'hE5, 5'h13, 5'h00, 12'h000, 4'h8);
    run(8'hE4, 5'h0F, 5'h00, 12'h3C3, 4'h0);
    wirq;
    chk("cont_again", 32'h1, {31'h0, irq_o});
    repeat (12) @(posedge clk_i);
    bus(1'b1, `SAD_OFS_CTRL, 32'h20);
    chk("power", 32'h1, {31'h0, adc_power_o});
    repeat (50) @(posedge clk_i);
    bus(1'b0, `SAD_OFS_RESULT, 32'h0);
    rsv(8'hE1, 5'h02, 5'h00, 4'h4);
    rsv(8'hE6, 5'h02, 5'h00, 4'hF);
    rsv(8'hFB, 5'h02, 5'h00, 4'h0);
    rsv(8'hE3, 5'h14, 5'h00, 4'h0);
    rsv(8'hF3, 5'h02, 5'h11, 4'h0);
    bus(1'b1, `SAD_OFS_IMASK, 32'h0);
    bus(1'b1, `SAD_OFS_CTRL, 32'hE3);
    repeat (90) @(posedge clk_i);
    chk("masked", 32'h0, {31'h0, irq_o});
    bus(1'b0, `SAD_OFS_STATUS, 32'h0);
    chk("sticky", 32'h1, rd);
    bus(1'b1, `SAD_OFS_IMASK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("unmasked", 32'h1, {31'h0, irq_o});
    bus(1'b0, `SAD_OFS_RESULT, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("cleared", 32'h0, {31'h0, irq_o});
    close_out;
  end
endmodule : test_sad_ctrl
`default_nettype wire
